// file: hdl/phbc_defs.vh
// Register map, field positions, reset values and timing constants of the phase build-out block
`ifndef PHBC_DEFS_VH
`define PHBC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define PHBC_A_FEAT        8'h48
`define PHBC_A_TRIM_LO     8'h70
`define PHBC_A_TRIM_HI     8'h71
`define PHBC_A_BIAS        8'h72
`define PHBC_A_JMON        8'h76

// ****************************************
// Reset values and field positions
// ****************************************
`define PHBC_FEAT_RST      8'h04
`define PHBC_JMON_RST      8'h30
`define PHBC_TRIM_RST      8'h00
`define PHBC_BIAS_RST      8'h00
`define PHBC_B_EN          2
`define PHBC_B_FRZ         3
`define PHBC_B_AUTO_A      4
`define PHBC_B_AUTO_B      5
`define PHBC_THR_MSB       3

// ****************************************
// Sizes and phase figures, phase LSB is 1 ps
// ****************************************
`define PHBC_NREF          14
`define PHBC_PW            28
`define PHBC_BW_MAX        5'h11
`define PHBC_TRIM_STEP_PS  28'h0000006
`define PHBC_BIAS_STEP_PS  28'h0000065
`define PHBC_BIAS_MAX      8'h0d
`define PHBC_START_PS      28'h0026160
`define PHBC_THR_BASE_PS   28'h00f4240
`define PHBC_THR_STEP_PS   28'h003d090
`define PHBC_THR_CODE_MAX  4'ha
`define PHBC_RESID_PS      28'h0001388
`define PHBC_SLEW_STEP_PS  28'h0000006

// ****************************************
// Timing
// ****************************************
`define PHBC_CLK_KHZ       25000
`define PHBC_WIN_MS        100
`define PHBC_BAD_US        500
`define PHBC_REPEAT_US     10000
`define PHBC_RESTORE_US    2000
`define PHBC_SETTLE_CYC    5'h10
`define PHBC_RETRY_MAX     2'h3
`define PHBC_SLEW_TOP      18'h20000

`endif

// file: hdl/phbc_ref_qual.v
// Per-reference quality qualifier: marks an input unserviceable and restores it
`timescale 1ns/10ps
`include "phbc_defs.vh"

module phbc_ref_qual #(
    parameter [19:0] BAD_CYC     = 20'd12500,
    parameter [19:0] REPEAT_CYC  = 20'd250000,
    parameter [19:0] RESTORE_CYC = 20'd50000
) (
    input  wire core_clk_i,
    input  wire reset_n_i,
    input  wire loss_i,
    input  wire freq_bad_i,
    input  wire short_int_i,
    input  wire kill_i,
    output reg  fail_o
);

    reg  [19:0] hold_cnt_q;
    reg  [19:0] rep_cnt_q;
    reg         strike_q;
    wire        bad;

    assign bad = loss_i | freq_bad_i;

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            hold_cnt_q <= 20'h00000;
            rep_cnt_q  <= 20'h00000;
            strike_q   <= 1'b0;
            fail_o     <= 1'b0;
        end else begin
            // Counts how long the quality disagrees with the current verdict
            if (bad == fail_o)
                hold_cnt_q <= 20'h00000;
            else
                hold_cnt_q <= hold_cnt_q + 20'h00001;
            if (short_int_i) begin
                strike_q  <= 1'b1;
                rep_cnt_q <= 20'h00000;
            end else if (strike_q) begin
                rep_cnt_q <= rep_cnt_q + 20'h00001;
                if (rep_cnt_q == REPEAT_CYC - 20'h00001)
                    strike_q <= 1'b0;
            end
            if (kill_i || (strike_q && short_int_i) ||
                (!fail_o && bad && hold_cnt_q == BAD_CYC - 20'h00001)) begin
                fail_o <= 1'b1;
            end else if (fail_o && !bad && hold_cnt_q == RESTORE_CYC - 20'h00001) begin
                fail_o <= 1'b0;
            end
        end
    end

endmodule

// file: hdl/phbc_ctrl.v
// Phase build-out, phase trim and reference qualification for the main timing path
//
// Function
// - Bandwidth code chooses one of 18 settings, 0.5 mHz to 70 Hz.
// - Loss of selected reference switches to next priority and starts absorption.
// - Deviation above 156 ns from internal output copy starts 0.1 s window.
// - Jump above threshold inside window absorbs automatically when both auto bits set.
// - External mode only flags 1 to 3.5 us jumps; host decides absorption.
// - Absorption holds over, measures input phase, then adds compensating offset.
// - Residual output transient after absorption checked against 5 ns; up to 3 retries, then accepted.
// - Absorption enabled, disabled or frozen by host; enabled at reset.
// - Frozen keeps current offset and ignores every further absorption event.
// - Disabling while locked slews offset to zero at bandwidth rate.
// - Enabling absorption while locked triggers an absorption event.
// - Build-out bias in 0.101 ns steps, limited to 13 steps (1.313 ns) either way.
// - Output phase trim in 6 ps steps up to 196.6 ns either way.
// - Trim shifts feedback clock phase, moving at bandwidth rate.
// - Trim acts only when enable bit and auto bit are both zero.
// - Failed reference leaves priority table until its quality recovers.
// - Single short interruption tolerated; longer, repeated or lock loss reselects.
// - Input held outside hold-in range long enough is rejected.
`timescale 1ns/10ps
`include "phbc_defs.vh"

module phbc_ctrl #(
    parameter [21:0] WIN_CYC     = `PHBC_WIN_MS * `PHBC_CLK_KHZ,
    parameter [19:0] BAD_CYC     = `PHBC_BAD_US * `PHBC_CLK_KHZ / 1000,
    parameter [19:0] REPEAT_CYC  = `PHBC_REPEAT_US * `PHBC_CLK_KHZ / 1000,
    parameter [19:0] RESTORE_CYC = `PHBC_RESTORE_US * `PHBC_CLK_KHZ / 1000
) (
    input  wire                      core_clk_i,
    input  wire                      reset_n_i,
    input  wire [7:0]                addr_i,
    input  wire                      wr_i,
    input  wire                      rd_i,
    input  wire [7:0]                wdata_i,
    output reg  [7:0]                rdata_o,
    input  wire [4:0]                bw_sel_i,
    input  wire                      locked_i,
    input  wire                      lock_lost_i,
    input  wire [`PHBC_PW-1:0]       phase_in_i,
    input  wire [`PHBC_NREF-1:0]     ref_loss_i,
    input  wire [`PHBC_NREF-1:0]     ref_freq_bad_i,
    input  wire [`PHBC_NREF-1:0]     ref_short_int_i,
    input  wire                      absorb_req_i,
    input  wire                      jump_clr_i,
    output reg                       jump_flag_o,
    output reg                       holdover_o,
    output reg                       absorb_evt_o,
    output reg  [`PHBC_PW-1:0]       dpll_offset_o,
    output reg  [`PHBC_PW-1:0]       fb_shift_o,
    output reg  [4:0]                bw_code_o,
    output reg  [3:0]                sel_ref_o,
    output reg                       sel_valid_o,
    output wire [`PHBC_NREF-1:0]     ref_unserv_o
);

    localparam [1:0] S_IDLE  = 2'd0;
    localparam [1:0] S_HOLD  = 2'd1;
    localparam [1:0] S_MEAS  = 2'd2;
    localparam [1:0] S_CHECK = 2'd3;

    // ****************************************
    // Phase helpers
    // ****************************************
    function [`PHBC_PW-1:0] mag;
        input [`PHBC_PW-1:0] v;
        begin
            mag = v[`PHBC_PW-1] ? (~v + 28'h0000001) : v;
        end
    endfunction

    // Moves cur toward tgt by at most step
    function [`PHBC_PW-1:0] slew;
        input [`PHBC_PW-1:0] cur;
        input [`PHBC_PW-1:0] tgt;
        input [`PHBC_PW-1:0] step;
        reg   [`PHBC_PW-1:0] d;
        begin
            d = tgt - cur;
            if ($signed(d) > $signed(step))
                slew = cur + step;
            else if ($signed(d) < -$signed(step))
                slew = cur - step;
            else
                slew = tgt;
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg  [7:0]           feat_q;
    reg  [7:0]           jmon_q;
    reg  [15:0]          trim_q;
    reg  [7:0]           bias_q;
    reg                  en_prev_q;
    reg  [1:0]           state_q;
    reg  [4:0]           settle_q;
    reg  [1:0]           retry_q;
    reg  [21:0]          win_cnt_q;
    reg                  win_on_q;
    reg                  auto_evt_q;
    reg                  switch_evt_q;
    reg  [17:0]          tick_cnt_q;
    reg                  tick_q;

    wire                 en;
    wire                 frz;
    wire                 auto_mode;
    wire                 trim_on;
    wire [3:0]           thr_code;
    wire [`PHBC_PW-1:0]  thr_ps;
    wire [`PHBC_PW-1:0]  dev_abs;
    wire [`PHBC_PW-1:0]  resid_abs;
    wire [7:0]           bias_c;
    wire [`PHBC_PW-1:0]  bias_ps;
    wire [`PHBC_PW-1:0]  trim_ps;
    wire [`PHBC_PW-1:0]  fb_tgt;
    wire [17:0]          tick_top;
    wire                 host_evt;
    wire                 ena_rise;
    wire                 evt;
    wire [`PHBC_NREF-1:0] unserv;

    assign en        = feat_q[`PHBC_B_EN];
    assign frz       = en & feat_q[`PHBC_B_FRZ];
    assign auto_mode = jmon_q[`PHBC_B_AUTO_B] & jmon_q[`PHBC_B_AUTO_A];
    assign trim_on   = !feat_q[`PHBC_B_EN] && !jmon_q[`PHBC_B_AUTO_A];

    // Jump threshold 1 us plus 0.25 us per code, capped at 3.5 us
    assign thr_code = (jmon_q[`PHBC_THR_MSB:0] > `PHBC_THR_CODE_MAX) ?
                      `PHBC_THR_CODE_MAX : jmon_q[`PHBC_THR_MSB:0];
    assign thr_ps   = `PHBC_THR_BASE_PS + `PHBC_THR_STEP_PS * {24'h000000, thr_code};

    // Offset register is the internal copy of the previous input phase
    assign dev_abs   = mag(phase_in_i - dpll_offset_o);

    // Build-out bias clamped to +-13 steps of 101 ps
    assign bias_c  = ($signed(bias_q) > $signed(`PHBC_BIAS_MAX)) ? `PHBC_BIAS_MAX :
                     ($signed(bias_q) < -$signed(`PHBC_BIAS_MAX)) ? (-`PHBC_BIAS_MAX) :
                     bias_q;
    assign bias_ps = {{20{bias_c[7]}}, bias_c} * `PHBC_BIAS_STEP_PS;
    assign resid_abs = mag(phase_in_i + bias_ps - dpll_offset_o);

    assign trim_ps = {{12{trim_q[15]}}, trim_q} * `PHBC_TRIM_STEP_PS;
    assign fb_tgt  = trim_on ? trim_ps : 28'h0000000;

    // Slew tick period halves for each step of wider bandwidth
    assign tick_top = `PHBC_SLEW_TOP >> bw_code_o;

    assign host_evt = absorb_req_i && !auto_mode;
    assign ena_rise = en && !en_prev_q && locked_i;
    assign evt      = (switch_evt_q || auto_evt_q || host_evt || ena_rise) &&
                      en && !frz;

    // ****************************************
    // Register port
    // ****************************************
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            feat_q  <= `PHBC_FEAT_RST;
            jmon_q  <= `PHBC_JMON_RST;
            trim_q  <= {`PHBC_TRIM_RST, `PHBC_TRIM_RST};
            bias_q  <= `PHBC_BIAS_RST;
            rdata_o <= 8'h00;
        end else begin
            if (wr_i) begin
                if (addr_i == `PHBC_A_FEAT)
                    feat_q <= wdata_i;
                else if (addr_i == `PHBC_A_TRIM_LO)
                    trim_q[7:0] <= wdata_i;
                else if (addr_i == `PHBC_A_TRIM_HI)
                    trim_q[15:8] <= wdata_i;
                else if (addr_i == `PHBC_A_BIAS)
                    bias_q <= wdata_i;
                else if (addr_i == `PHBC_A_JMON)
                    jmon_q <= wdata_i;
            end
            if (rd_i) begin
                if (addr_i == `PHBC_A_FEAT)
                    rdata_o <= feat_q;
                else if (addr_i == `PHBC_A_TRIM_LO)
                    rdata_o <= trim_q[7:0];
                else if (addr_i == `PHBC_A_TRIM_HI)
                    rdata_o <= trim_q[15:8];
                else if (addr_i == `PHBC_A_BIAS)
                    rdata_o <= bias_q;
                else if (addr_i == `PHBC_A_JMON)
                    rdata_o <= jmon_q;
                else
                    rdata_o <= 8'h00;
            end
        end
    end

    // ****************************************
    // Bandwidth and slew tick
    // ****************************************
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            bw_code_o  <= 5'h00;
            tick_cnt_q <= 18'h00000;
            tick_q     <= 1'b0;
        end else begin
            bw_code_o <= (bw_sel_i > `PHBC_BW_MAX) ? `PHBC_BW_MAX : bw_sel_i;
            if (tick_cnt_q >= tick_top - 18'h00001) begin
                tick_cnt_q <= 18'h00000;
                tick_q     <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 18'h00001;
                tick_q     <= 1'b0;
            end
        end
    end

    // ****************************************
    // Jump monitor window
    // ****************************************
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            win_on_q    <= 1'b0;
            win_cnt_q   <= 22'h000000;
            auto_evt_q  <= 1'b0;
            jump_flag_o <= 1'b0;
        end else begin
            auto_evt_q <= 1'b0;
            if (!win_on_q) begin
                if (state_q == S_IDLE && dev_abs > `PHBC_START_PS) begin
                    win_on_q  <= 1'b1;
                    win_cnt_q <= 22'h000000;
                end
            end else if (dev_abs > thr_ps) begin
                win_on_q <= 1'b0;
                if (auto_mode)
                    auto_evt_q <= 1'b1;
            end else if (win_cnt_q == WIN_CYC - 22'h000001) begin
                win_on_q <= 1'b0;
            end else begin
                win_cnt_q <= win_cnt_q + 22'h000001;
            end
            // Set beats clear in the same cycle
            if (win_on_q && dev_abs > thr_ps && !auto_mode)
                jump_flag_o <= 1'b1;
            else if (jump_clr_i)
                jump_flag_o <= 1'b0;
        end
    end

    // ****************************************
    // Reference selection
    // ****************************************
    reg  [3:0] best;
    reg        found;
    integer    i;

    always @* begin
        best  = 4'h0;
        found = 1'b0;
        for (i = `PHBC_NREF - 1; i >= 0; i = i - 1) begin
            if (!unserv[i]) begin
                best  = i[3:0];
                found = 1'b1;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sel_ref_o    <= 4'h0;
            sel_valid_o  <= 1'b0;
            switch_evt_q <= 1'b0;
        end else begin
            switch_evt_q <= 1'b0;
            if (!sel_valid_o || unserv[sel_ref_o]) begin
                if (found) begin
                    sel_ref_o    <= best;
                    sel_valid_o  <= 1'b1;
                    switch_evt_q <= sel_valid_o;
                end else begin
                    sel_valid_o <= 1'b0;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PHBC_NREF; g = g + 1) begin : g_qual
            phbc_ref_qual #(
                .BAD_CYC     (BAD_CYC),
                .REPEAT_CYC  (REPEAT_CYC),
                .RESTORE_CYC (RESTORE_CYC)
            ) u_qual (
                .core_clk_i  (core_clk_i),
                .reset_n_i   (reset_n_i),
                .loss_i      (ref_loss_i[g]),
                .freq_bad_i  (ref_freq_bad_i[g]),
                .short_int_i (ref_short_int_i[g]),
                .kill_i      (lock_lost_i && sel_valid_o && sel_ref_o == g),
                .fail_o      (unserv[g])
            );
        end
    endgenerate

    assign ref_unserv_o = unserv;

    // ****************************************
    // Absorption sequence and output phase
    // ****************************************
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_q       <= S_IDLE;
            settle_q      <= 5'h00;
            retry_q       <= 2'h0;
            holdover_o    <= 1'b0;
            absorb_evt_o  <= 1'b0;
            dpll_offset_o <= 28'h0000000;
            fb_shift_o    <= 28'h0000000;
            en_prev_q     <= 1'b1;
        end else begin
            en_prev_q    <= en;
            absorb_evt_o <= 1'b0;
            if (tick_q)
                fb_shift_o <= slew(fb_shift_o, fb_tgt, `PHBC_SLEW_STEP_PS);
            case (state_q)
                S_IDLE: begin
                    if (evt) begin
                        state_q      <= S_HOLD;
                        holdover_o   <= 1'b1;
                        absorb_evt_o <= 1'b1;
                        settle_q     <= 5'h00;
                        retry_q      <= 2'h0;
                    end else if (!en && locked_i && tick_q) begin
                        dpll_offset_o <= slew(dpll_offset_o, 28'h0000000,
                                              `PHBC_SLEW_STEP_PS);
                    end
                end
                S_HOLD: begin
                    if (settle_q == `PHBC_SETTLE_CYC - 5'h01)
                        state_q <= S_MEAS;
                    else
                        settle_q <= settle_q + 5'h01;
                end
                S_MEAS: begin
                    dpll_offset_o <= phase_in_i + bias_ps;
                    state_q       <= S_CHECK;
                end
                default: begin
                    if (resid_abs <= `PHBC_RESID_PS || retry_q == `PHBC_RETRY_MAX) begin
                        state_q    <= S_IDLE;
                        holdover_o <= 1'b0;
                    end else begin
                        retry_q  <= retry_q + 2'h1;
                        settle_q <= 5'h00;
                        state_q  <= S_HOLD;
                    end
                end
            endcase
        end
    end

endmodule

// file: bench/phbc_ctrl_chk.sv
// Port checker for the phase build-out controller
`timescale 1ns/10ps
`include "phbc_defs.vh"
module phbc_ctrl_chk (
    input wire                  core_clk_i,
    input wire                  reset_n_i,
    input wire                  lock_lost_i,
    input wire                  jump_clr_i,
    input wire                  jump_flag_o,
    input wire                  holdover_o,
    input wire                  absorb_evt_o,
    input wire [`PHBC_PW-1:0]   dpll_offset_o,
    input wire [4:0]            bw_code_o,
    input wire [3:0]            sel_ref_o,
    input wire                  sel_valid_o,
    input wire [`PHBC_NREF-1:0] ref_unserv_o
);
// ****************************************
// Sequences and assertions
// ****************************************
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (!reset_n_i);
sequence s_evt;
    absorb_evt_o && holdover_o;
endsequence
sequence s_settle;
    $stable(dpll_offset_o) [*8];
endsequence
a_bw_range: assert property (bw_code_o <= 5'h11)
    else $error("bandwidth code too high");
a_evt_pulse: assert property (absorb_evt_o |=> !absorb_evt_o)
    else $error("event longer than a cycle");
a_evt_hold: assert property (absorb_evt_o |-> s_evt)
    else $error("event without holdover");
a_settle_hold: assert property (s_evt |-> holdover_o [*8])
    else $error("holdover too short");
a_settle_offset: assert property (s_evt |-> ##2 s_settle)
    else $error("offset moved while settling");
a_busy_refuse: assert property (holdover_o && $past(holdover_o) |-> !absorb_evt_o)
    else $error("event taken while busy");
a_flag_hold: assert property (jump_flag_o && !jump_clr_i |=> jump_flag_o)
    else $error("jump flag dropped");
a_kill_sel: assert property (sel_valid_o && lock_lost_i |=> ref_unserv_o[$past(sel_ref_o)])
    else $error("lost reference kept");
a_sel_serv: assert property (sel_valid_o && $stable(ref_unserv_o) |-> !ref_unserv_o[sel_ref_o])
    else $error("unserviceable reference selected");
endmodule

bind phbc_ctrl phbc_ctrl_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .lock_lost_i(lock_lost_i), .jump_clr_i(jump_clr_i), .jump_flag_o(jump_flag_o),
    .holdover_o(holdover_o), .absorb_evt_o(absorb_evt_o), .dpll_offset_o(dpll_offset_o),
    .bw_code_o(bw_code_o), .sel_ref_o(sel_ref_o), .sel_valid_o(sel_valid_o),
    .ref_unserv_o(ref_unserv_o));

// file: bench/phbc_src_model.sv
// Behavioural model of the reference inputs and DPLL status
`timescale 1ns/10ps
`include "phbc_defs.vh"
module phbc_src_model (
    input  wire                  core_clk_i,
    input  wire [`PHBC_PW-1:0]   ph_cmd_i,
    input  wire [`PHBC_NREF-1:0] loss_cmd_i,
    input  wire [`PHBC_NREF-1:0] bad_cmd_i,
    input  wire [`PHBC_NREF-1:0] short_cmd_i,
    input  wire                  kill_cmd_i,
    output reg  [`PHBC_PW-1:0]   phase_in_o,
    output reg  [`PHBC_NREF-1:0] ref_loss_o,
    output reg  [`PHBC_NREF-1:0] ref_freq_bad_o,
    output reg  [`PHBC_NREF-1:0] ref_short_int_o,
    output reg                   lock_lost_o,
    output reg                   locked_o
);
reg [`PHBC_NREF-1:0] short_q = 14'h0000;
reg                  kill_q  = 1'b0;
initial begin
    {phase_in_o, ref_loss_o, ref_freq_bad_o, ref_short_int_o, lock_lost_o} = 0;
    locked_o = 1'b1;
end
always @(posedge core_clk_i) begin
    phase_in_o      <= ph_cmd_i;
    ref_loss_o      <= loss_cmd_i;
    ref_freq_bad_o  <= bad_cmd_i;
    ref_short_int_o <= short_cmd_i & ~short_q;
    short_q         <= short_cmd_i;
    lock_lost_o     <= kill_cmd_i & ~kill_q;
    kill_q          <= kill_cmd_i;
    // Frame-rate lock taken as engaged, so big steps are followed
    locked_o        <= 1'b1;
end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the phase build-out controller
`timescale 1ns/10ps
`include "phbc_defs.vh"
module tb_top;
reg          core_clk = 1'b0;
reg          reset_n  = 1'b0;
reg  [7:0]   addr = 8'h00, wdata = 8'h00;
reg          wr = 1'b0, rd = 1'b0, req = 1'b0, clr = 1'b0, kill = 1'b0;
reg  [4:0]   bw_sel = 5'h11;
reg  [27:0]  ph = 28'h0000000, p, o1;
reg  [13:0]  loss = 14'h0000, bad = 14'h0000, shrt = 14'h0000;
wire [27:0]  phase_in, offs, fbs;
wire [13:0]  rloss, rbad, rshort, unserv;
wire [7:0]   rdata;
wire [4:0]   bw_code;
wire [3:0]   sel;
wire         locked, lost, flag, hold, evt, selv;
integer      errors = 0, samples_checked = 0, evt_cnt = 0, cyc = 0, k;

phbc_src_model u_src (.core_clk_i(core_clk), .ph_cmd_i(ph), .loss_cmd_i(loss),
    .bad_cmd_i(bad), .short_cmd_i(shrt), .kill_cmd_i(kill), .phase_in_o(phase_in),
    .ref_loss_o(rloss), .ref_freq_bad_o(rbad), .ref_short_int_o(rshort),
    .lock_lost_o(lost), .locked_o(locked));
phbc_ctrl #(.WIN_CYC(22'd200), .BAD_CYC(20'd20), .REPEAT_CYC(20'd50),
    .RESTORE_CYC(20'd30)) uut (.core_clk_i(core_clk), .reset_n_i(reset_n),
    .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
    .bw_sel_i(bw_sel), .locked_i(locked), .lock_lost_i(lost), .phase_in_i(phase_in),
    .ref_loss_i(rloss), .ref_freq_bad_i(rbad), .ref_short_int_i(rshort),
    .absorb_req_i(req), .jump_clr_i(clr), .jump_flag_o(flag), .holdover_o(hold),
    .absorb_evt_o(evt), .dpll_offset_o(offs), .fb_shift_o(fbs), .bw_code_o(bw_code),
    .sel_ref_o(sel), .sel_valid_o(selv), .ref_unserv_o(unserv));
// ****************************************
// Clock, event count and timeout
// ****************************************
initial forever #20 core_clk = ~core_clk;
always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (evt === 1'b1) evt_cnt = evt_cnt + 1;
    if (cyc == 6000) begin
        errors = errors + 1;
        tally_and_finish;
    end
end
// ****************************************
// Tasks
// ****************************************
task chk(input [27:0] seen, input [27:0] exp);
begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
end
endtask
// Build-out bias expected from the clamp to +-13 steps of 101 ps
function [27:0] exp_bias(input integer code);
    exp_bias = ((code > 13) ? 13 : (code < -13) ? -13 : code) * 101;
endfunction
task tick(input integer n);
    repeat (n) @(negedge core_clk);
endtask
task wrr(input [7:0] a, input [7:0] d);
begin
    @(posedge core_clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk); wr <= 1'b0;
end
endtask
task rdc(input [7:0] a, input [7:0] e);
begin
    @(posedge core_clk); addr <= a; rd <= 1'b1;
    @(posedge core_clk); rd <= 1'b0;
    @(negedge core_clk); chk(rdata, e);
end
endtask
task wait_idle;
begin
    tick(6);
    k = 0;
    while (hold !== 1'b0 && k < 100) begin
        @(negedge core_clk);
        k = k + 1;
    end
    chk(hold, 1'b0);
end
endtask
task tally_and_finish;
begin
    if (errors == 0 && samples_checked > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
end
endtask
// ****************************************
// Main sequence
// ****************************************
initial begin
    p = $urandom(73);
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    rdc(`PHBC_A_FEAT, `PHBC_FEAT_RST);
    rdc(`PHBC_A_JMON, `PHBC_JMON_RST);
    rdc(`PHBC_A_TRIM_LO, `PHBC_TRIM_RST);
    rdc(`PHBC_A_BIAS, `PHBC_BIAS_RST);
    rdc(8'h55, 8'h00);
    o1 = $urandom;
    wrr(`PHBC_A_TRIM_HI, o1[7:0]);
    rdc(`PHBC_A_TRIM_HI, o1[7:0]);
    wrr(`PHBC_A_TRIM_HI, 8'h00);
    for (k = 0; k < 19; k = k + 1) begin
        @(posedge core_clk); bw_sel <= (k == 18) ? 5'h1f : k;
        tick(3); chk(bw_code, (k == 18) ? 17 : k);
    end
    p = 28'd1500000 + ($urandom % 1000000);
    @(posedge core_clk); ph <= p;
    wait_idle;
    chk(evt_cnt, 1);
    chk(offs, p);
    chk(flag, 0);
    wrr(`PHBC_A_BIAS, 8'h7f);
    @(posedge core_clk); kill <= 1'b1; loss[0] <= 1'b1;
    @(posedge core_clk); kill <= 1'b0;
    wait_idle;
    chk(unserv[0], 1);
    chk(sel, 1);
    chk(selv, 1);
    chk(evt_cnt, 2);
    chk(offs, p + exp_bias(127));
    wrr(`PHBC_A_FEAT, 8'h0c);
    @(posedge core_clk); kill <= 1'b1; loss[1] <= 1'b1;
    @(posedge core_clk); kill <= 1'b0;
    tick(40);
    chk(sel, 2);
    chk(evt_cnt, 2);
    chk(offs, p + 28'd1313);
    wrr(`PHBC_A_FEAT, 8'h04);
    wrr(`PHBC_A_JMON, 8'h0f);
    p = p + 28'd1313 + 28'd2000000;
    @(posedge core_clk); ph <= p;
    tick(8);
    chk(flag, 0);
    wrr(`PHBC_A_JMON, 8'h00);
    tick(8);
    chk(flag, 1);
    tick(20);
    chk(evt_cnt, 2);
    chk(flag, 1);
    @(posedge core_clk); req <= 1'b1;
    @(posedge core_clk); req <= 1'b0;
    wait_idle;
    chk(evt_cnt, 3);
    chk(offs, p + exp_bias(127));
    @(posedge core_clk); clr <= 1'b1;
    @(posedge core_clk); clr <= 1'b0;
    tick(3); chk(flag, 0);
    wrr(`PHBC_A_FEAT, 8'h00);
    wrr(`PHBC_A_TRIM_LO, 8'h0a);
    tick(30); chk(fbs, 28'd60);
    o1 = offs;
    tick(10); chk(o1 - offs, 28'd60);
    wrr(`PHBC_A_FEAT, 8'h04);
    wait_idle;
    chk(evt_cnt, 4);
    for (k = 0; k < 2; k = k + 1) begin
        @(posedge core_clk); shrt[5] <= 1'b1;
        @(posedge core_clk); shrt[5] <= 1'b0;
        tick(8); chk(unserv[5], k);
    end
    @(posedge core_clk); bad[6] <= 1'b1;
    tick(26); chk(unserv[6], 1);
    @(posedge core_clk); bad[6] <= 1'b0;
    tick(40); chk(unserv[6], 0);
    tally_and_finish;
end
endmodule
